// ---- mcuirq_pkg.sv ----
package mcuirq_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OPTION     = 8'h04;
  localparam logic [7:0] ADDR_PERIPH_FLG = 8'h08;
  localparam logic [7:0] ADDR_PERIPH_EN  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;

  // Field positions of irq_control_reg
  localparam int BIT_GIE       = 7;
  localparam int BIT_TMR_EN    = 5;
  localparam int BIT_EXT_EN    = 4;
  localparam int BIT_PORT_EN   = 3;
  localparam int BIT_TMR_FLAG  = 2;
  localparam int BIT_EXT_FLAG  = 1;
  localparam int BIT_PORT_FLAG = 0;
  // Field positions of option and peripheral registers
  localparam int BIT_EDGE_SEL  = 6;
  localparam int BIT_PERIPH    = 0;
  // Field positions of status register
  localparam int BIT_ST_PEND   = 0;
  localparam int BIT_ST_SLEEP  = 1;
  localparam int BIT_ST_ENTRY  = 2;
  localparam int BIT_ST_NOPBLK = 3;

  // Reset values
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] OPTION_RST   = 8'hff;
  localparam logic       PERIPH_RST   = 1'b0;

  // Service address and timing
  localparam int             PC_W        = 13;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
  localparam int             Q_PER_INSTR = 4;
  localparam int             NUM_SOURCES = 4;
  localparam logic [7:0]     TMR_TOP     = 8'hff;
  localparam logic [7:0]     TMR_ZERO    = 8'h00;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTRY,
    ST_SLEEP,
    ST_WAKE
  } mcuirq_state_t;
endpackage

// ---- mcuirq_evt_detect.sv ----
`timescale 1ns/1ps
module mcuirq_evt_detect (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ext_irq_pin,
  input  wire logic       ext_edge_select,
  input  wire logic [3:0] upper_io_port,
  input  wire logic       port_read,
  output logic            ext_evt,
  output logic            port_evt
);
  import mcuirq_pkg::*;

  typedef struct packed {
    logic       armed;
    logic       pin_prev;
    logic [3:0] port_latch;
    logic       ext_evt;
    logic       port_evt;
  } mcuirq_det_t;

  mcuirq_det_t det_reg;
  mcuirq_det_t det_next;

  // Edge and mismatch detection
  always_comb begin
    det_next          = det_reg;
    det_next.armed    = 1'b1;
    det_next.pin_prev = ext_irq_pin;
    // Selected edge of the pin, ignored on the first cycle after reset
    det_next.ext_evt  = det_reg.armed &&
                        (ext_edge_select ? (ext_irq_pin && !det_reg.pin_prev)
                                         : (!ext_irq_pin && det_reg.pin_prev));
    // Mismatch against the value last read; lost during a read cycle
    det_next.port_evt = (upper_io_port != det_reg.port_latch) && !port_read;
    if (port_read) begin
      det_next.port_latch = upper_io_port;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_reg <= '0;
    end else begin
      det_reg <= det_next;
    end
  end

  assign ext_evt  = det_reg.ext_evt;
  assign port_evt = det_reg.port_evt;

  a_rise_edge : assert property (@(posedge aclk) disable iff (!aresetn)
    det_reg.armed && ext_edge_select && ext_irq_pin && !det_reg.pin_prev |=> ext_evt)
    else $error("rising edge not detected");
endmodule

// ---- mcuirq_core.sv ----
`timescale 1ns/1ps
module mcuirq_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        ext_irq_pin,
  input  wire logic [3:0]                  upper_io_port,
  input  wire logic                        port_read,
  input  wire logic [7:0]                  timer_count_reg,
  input  wire logic                        periph_event,
  input  wire logic                        return_from_irq_instr,
  input  wire logic                        gie_clear_instr,
  input  wire logic                        sleep_instr,
  output logic                             irq_request,
  output logic                             vector_load,
  output logic                             push_return,
  output logic [mcuirq_pkg::PC_W-1:0]      vector_addr,
  output logic                             exec_nop,
  output logic                             core_asleep,
  output logic                             core_wake,
  output logic [1:0]                       instr_phase
);
  import mcuirq_pkg::*;

  localparam logic [1:0] Q_LAST = 2'(Q_PER_INSTR - 1);

  typedef struct packed {
    mcuirq_state_t st;
    logic [1:0]    q;
    logic          dleft;
    logic          nop_blk;
    logic [7:0]    ctrl;
    logic [7:0]    option;
    logic          pflag;
    logic          pen;
    logic [7:0]    tmr_prev;
    logic          tmr_armed;
    logic          awv;
    logic [ADDR_W-1:0] awaddr;
    logic          wv;
    logic [7:0]    wdata;
    logic          wstb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [7:0]    rdata;
    logic [1:0]    rresp;
    logic          wake;
  } mcuirq_core_t;

  mcuirq_core_t s_reg;
  mcuirq_core_t s_next;

  logic ext_evt;
  logic port_evt;
  logic tmr_evt;
  logic boundary;
  logic pend;
  logic take;
  wire logic [8:0] ar_word = rd_word(s_axi_araddr, s_reg, pend);
  wire logic [8:0] aw_word = rd_word(s_reg.awaddr, s_reg, pend);

  // Pin edge and port change detection
  mcuirq_evt_detect u_det (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .ext_irq_pin     (ext_irq_pin),
    .ext_edge_select (s_reg.option[BIT_EDGE_SEL]),
    .upper_io_port   (upper_io_port),
    .port_read       (port_read),
    .ext_evt         (ext_evt),
    .port_evt        (port_evt)
  );

  // Read data for one register address
  function automatic logic [8:0] rd_word(input logic [ADDR_W-1:0] a, input mcuirq_core_t s,
                                         input logic p);
    logic [8:0] v;
    v = {1'b1, 8'h00};
    if (a == ADDR_W'(ADDR_IRQ_CTRL)) begin
      v[7:0] = s.ctrl;
    end else if (a == ADDR_W'(ADDR_OPTION)) begin
      v[7:0] = s.option;
    end else if (a == ADDR_W'(ADDR_PERIPH_FLG)) begin
      v[BIT_PERIPH] = s.pflag;
    end else if (a == ADDR_W'(ADDR_PERIPH_EN)) begin
      v[BIT_PERIPH] = s.pen;
    end else if (a == ADDR_W'(ADDR_STATUS)) begin
      v[BIT_ST_PEND]   = p;
      v[BIT_ST_SLEEP]  = (s.st == ST_SLEEP);
      v[BIT_ST_ENTRY]  = (s.st == ST_ENTRY);
      v[BIT_ST_NOPBLK] = s.nop_blk;
    end else begin
      v[8] = 1'b0;
    end
    return v;
  endfunction

  // Source events and request decision
  always_comb begin
    tmr_evt  = s_reg.tmr_armed && (s_reg.tmr_prev == TMR_TOP) &&
               (timer_count_reg == TMR_ZERO);
    boundary = (s_reg.q == Q_LAST);
    // Any enabled source, without the global enable; this also wakes
    pend = (s_reg.ctrl[BIT_EXT_FLAG]  && s_reg.ctrl[BIT_EXT_EN])  ||
           (s_reg.ctrl[BIT_TMR_FLAG]  && s_reg.ctrl[BIT_TMR_EN])  ||
           (s_reg.ctrl[BIT_PORT_FLAG] && s_reg.ctrl[BIT_PORT_EN]) ||
           (s_reg.pflag && s_reg.pen);
    irq_request = pend && s_reg.ctrl[BIT_GIE];
    // Taken only at an instruction boundary, never in the blocked cycle
    take = boundary && (s_reg.st == ST_RUN) && irq_request &&
           !s_reg.nop_blk && !gie_clear_instr;
  end

  // Next state
  always_comb begin
    s_next           = s_reg;
    s_next.q         = s_reg.q + 2'h1;
    s_next.tmr_prev  = timer_count_reg;
    s_next.tmr_armed = 1'b1;
    s_next.wake      = 1'b0;

    // Bus: capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_next.awv    = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_next.wv    = 1'b1;
      s_next.wdata = s_axi_wdata[7:0];
      s_next.wstb  = s_axi_wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = ar_word[7:0];
      s_next.rresp  = ar_word[8] ? RESP_OKAY : RESP_SLVERR;
    end

    // Software write once both halves are held
    if (s_reg.awv && s_reg.wv && !s_reg.bvalid) begin
      s_next.awv    = 1'b0;
      s_next.wv     = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = aw_word[8] ? RESP_OKAY : RESP_SLVERR;
      if (s_reg.wstb) begin
        if (s_reg.awaddr == ADDR_W'(ADDR_IRQ_CTRL)) begin
          s_next.ctrl = s_reg.wdata;
        end else if (s_reg.awaddr == ADDR_W'(ADDR_OPTION)) begin
          s_next.option = s_reg.wdata;
        end else if (s_reg.awaddr == ADDR_W'(ADDR_PERIPH_FLG)) begin
          s_next.pflag = s_reg.wdata[BIT_PERIPH];
        end else if (s_reg.awaddr == ADDR_W'(ADDR_PERIPH_EN)) begin
          s_next.pen = s_reg.wdata[BIT_PERIPH];
        end
      end
    end

    // Hardware sets flags after the software write, so a set wins
    if (ext_evt) begin
      s_next.ctrl[BIT_EXT_FLAG] = 1'b1;
    end
    if (tmr_evt) begin
      s_next.ctrl[BIT_TMR_FLAG] = 1'b1;
    end
    if (port_evt) begin
      s_next.ctrl[BIT_PORT_FLAG] = 1'b1;
    end
    if (periph_event) begin
      s_next.pflag = 1'b1;
    end

    // Global enable: return sets it, instruction clear and entry clear it
    if (return_from_irq_instr) begin
      s_next.ctrl[BIT_GIE] = 1'b1;
    end
    if (gie_clear_instr || take) begin
      s_next.ctrl[BIT_GIE] = 1'b0;
    end

    // One blocked instruction cycle after a global-enable clear
    if (gie_clear_instr) begin
      s_next.nop_blk = 1'b1;
    end else if (boundary) begin
      s_next.nop_blk = 1'b0;
    end

    // Entry, sleep and wake sequencing
    unique case (s_reg.st)
      ST_RUN: begin
        if (take) begin
          s_next.st    = ST_ENTRY;
          s_next.dleft = 1'b1;
        end else if (sleep_instr) begin
          s_next.st = ST_SLEEP;
        end
      end
      ST_ENTRY: begin
        if (boundary) begin
          s_next.dleft = 1'b0;
          if (!s_reg.dleft) begin
            s_next.st = ST_RUN;
          end
        end
      end
      ST_SLEEP: begin
        if (pend) begin
          s_next.st   = ST_WAKE;
          s_next.wake = 1'b1;
        end
      end
      ST_WAKE: begin
        if (boundary) begin
          s_next.st = ST_RUN;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg        <= '0;
      s_reg.st     <= ST_RUN;
      s_reg.ctrl   <= IRQ_CTRL_RST;
      s_reg.option <= OPTION_RST;
      s_reg.pflag  <= PERIPH_RST;
      s_reg.pen    <= PERIPH_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Bus handshakes
  assign s_axi_awready = !s_reg.awv && !s_reg.bvalid;
  assign s_axi_wready  = !s_reg.wv && !s_reg.bvalid;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rresp   = s_reg.rresp;
  assign s_axi_rdata   = {24'h000000, s_reg.rdata};

  // Core-facing outputs
  assign vector_load = take;
  assign push_return = take;
  assign vector_addr = VECTOR_ADDR;
  assign exec_nop    = (s_reg.st == ST_ENTRY) || s_reg.nop_blk;
  assign core_asleep = (s_reg.st == ST_SLEEP);
  assign core_wake   = s_reg.wake;
  assign instr_phase = s_reg.q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_entry_dummy;
    (s_reg.st == ST_ENTRY)[*8] ##1 (s_reg.st != ST_ENTRY);
  endsequence

  sequence s_pin_ready;
    $rose(s_reg.ctrl[BIT_EXT_FLAG]) && s_reg.ctrl[BIT_EXT_EN] && s_reg.ctrl[BIT_GIE] &&
    (s_reg.st == ST_RUN) && !s_reg.nop_blk && !gie_clear_instr;
  endsequence

  a_reset_gie_clear : assert property (disable iff (1'b0)
    !aresetn |=> !s_reg.ctrl[BIT_GIE])
    else $error("global enable not cleared by reset");
  a_take_needs_gie : assert property (take |-> s_reg.ctrl[BIT_GIE] && pend)
    else $error("request taken without global enable");
  a_entry_sequence : assert property (take |=> !s_reg.ctrl[BIT_GIE] ##0 s_entry_dummy)
    else $error("entry did not clear enable or run two dummy cycles");
  a_return_sets_gie : assert property (return_from_irq_instr && !take && !gie_clear_instr
    |=> s_reg.ctrl[BIT_GIE])
    else $error("return did not set global enable");
  a_ext_flag_set : assert property (ext_evt |=> s_reg.ctrl[BIT_EXT_FLAG])
    else $error("pin flag not set");
  a_timer_flag_set : assert property (tmr_evt |=> s_reg.ctrl[BIT_TMR_FLAG])
    else $error("timer flag not set");
  a_nop_blocks_take : assert property (gie_clear_instr |-> ##1 (!take)[*4])
    else $error("request taken in blocked cycle");
  a_pin_latency : assert property (s_pin_ready |-> ##[0:3] take)
    else $error("pin request not taken at next boundary");
  a_wake_no_gie : assert property (core_asleep && pend |=> !core_asleep && core_wake)
    else $error("enabled source did not wake core");
  a_wake_then_vec : assert property (core_wake |-> !take ##1 (!take)[*3])
    else $error("vector taken before instruction after sleep");
endmodule

// ---- mcuirq_cpu_model.sv ----
`timescale 1ns/1ps
// Core model: issues instruction pulses and tracks the return stack
module mcuirq_cpu_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] op_sel,
  input  wire logic       op_go,
  output logic            op_done,
  input  wire logic       push_return,
  output logic            return_from_irq_instr,
  output logic            gie_clear_instr,
  output logic            sleep_instr,
  output logic [3:0]      stack_depth
);
  logic fire;

  // New op only once per request handshake
  assign fire = op_go && !op_done;

  // One-cycle instruction pulses, stack depth counts return addresses only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_done               <= 1'b0;
      return_from_irq_instr <= 1'b0;
      gie_clear_instr       <= 1'b0;
      sleep_instr           <= 1'b0;
      stack_depth           <= 4'h0;
    end else begin
      op_done               <= fire;
      return_from_irq_instr <= fire && op_sel == 2'd0;
      gie_clear_instr       <= fire && op_sel == 2'd1;
      sleep_instr           <= fire && op_sel == 2'd2;
      stack_depth           <= stack_depth + 4'(push_return) - 4'(fire && op_sel == 2'd0);
    end
  end
endmodule

// ---- tb_mcu_interrupt_logic.sv ----
`timescale 1ns/1ps
module tb_mcu_interrupt_logic;
  import mcuirq_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, timer_count_reg = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, upper_io_port = 4'h0, stack_depth, pv;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, instr_phase, op_sel = 2'd0;
  logic ext_irq_pin = 1'b0, port_read = 1'b0, periph_event = 1'b0, op_go = 1'b0, op_done;
  logic return_from_irq_instr, gie_clear_instr, sleep_instr, irq_request, vector_load, push_return;
  logic exec_nop, core_asleep, core_wake;
  logic [PC_W-1:0] vector_addr;
  logic [33:0] rq[$], bq[$];
  int err_count = 0, tests_run = 0, vec_count = 0, wake_count = 0, nop_count = 0;

  mcuirq_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ext_irq_pin(ext_irq_pin), .upper_io_port(upper_io_port), .port_read(port_read),
    .timer_count_reg(timer_count_reg), .periph_event(periph_event), .return_from_irq_instr(return_from_irq_instr),
    .gie_clear_instr(gie_clear_instr), .sleep_instr(sleep_instr), .irq_request(irq_request),
    .vector_load(vector_load), .push_return(push_return), .vector_addr(vector_addr), .exec_nop(exec_nop),
    .core_asleep(core_asleep), .core_wake(core_wake), .instr_phase(instr_phase));

  mcuirq_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .op_sel(op_sel), .op_go(op_go), .op_done(op_done),
    .push_return(push_return), .return_from_irq_instr(return_from_irq_instr), .gie_clear_instr(gie_clear_instr),
    .sleep_instr(sleep_instr), .stack_depth(stack_depth));

  // Clock generator
  always #5 aclk = ~aclk;

  // Compares one value and counts
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus write, expected response queued
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    bq.push_back({32'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Bus read, expected response and data queued
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    rq.push_back({r, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Asks the core model for one instruction
  task automatic op(input logic [1:0] s);
    op_sel <= s;
    op_go <= 1'b1;
    do @(posedge aclk); while (op_done !== 1'b1);
    op_go <= 1'b0;
  endtask

  // Timer rollover from top to zero
  task automatic ovf();
    timer_count_reg <= TMR_TOP;
    @(posedge aclk);
    timer_count_reg <= TMR_ZERO;
    tick(3);
  endtask

  // Output watcher: pops oldest expectation per answer
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) check({32'h0, s_axi_bresp}, bq.pop_front());
    if (vector_load === 1'b1) begin
      vec_count++;
      check(34'(vector_addr), 34'h4);
      check(34'(instr_phase), 34'(Q_PER_INSTR - 1));
    end
    if (core_wake === 1'b1) wake_count++;
    if (exec_nop === 1'b1) nop_count++;
  end

  // Hang guard
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    void'($urandom(79379));
    tick(5);
    aresetn <= 1'b1;
    tick(1);
    rd(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
    rd(ADDR_OPTION, 8'hff, RESP_OKAY);
    rd(ADDR_PERIPH_EN, 8'h00, RESP_OKAY);
    rd(8'h14, 8'h00, RESP_SLVERR);
    wr(8'h14, 8'hff, RESP_SLVERR);
    ovf();
    rd(ADDR_IRQ_CTRL, 8'h04, RESP_OKAY);
    ext_irq_pin <= 1'b1;
    tick(3);
    rd(ADDR_IRQ_CTRL, 8'h06, RESP_OKAY);
    wr(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
    ext_irq_pin <= 1'b0;
    tick(3);
    rd(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
    wr(ADDR_OPTION, 8'hbf, RESP_OKAY);
    ext_irq_pin <= 1'b1;
    tick(3);
    rd(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
    ext_irq_pin <= 1'b0;
    tick(3);
    rd(ADDR_IRQ_CTRL, 8'h02, RESP_OKAY);
    pv = 4'($urandom_range(15, 1));
    upper_io_port <= pv;
    tick(3);
    rd(ADDR_IRQ_CTRL, 8'h03, RESP_OKAY);
    port_read <= 1'b1;
    tick(1);
    port_read <= 1'b0;
    wr(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
    rd(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
    periph_event <= 1'b1;
    tick(1);
    periph_event <= 1'b0;
    tick(2);
    rd(ADDR_PERIPH_FLG, 8'h01, RESP_OKAY);
    rd(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
    wr(ADDR_PERIPH_FLG, 8'h00, RESP_OKAY);
    // Pin request taken with global enable set
    ext_irq_pin <= 1'b1;
    tick(3);
    wr(ADDR_IRQ_CTRL, 8'h90, RESP_OKAY);
    ext_irq_pin <= 1'b0;
    tick(16);
    check(34'(vec_count), 34'd1);
    check(34'(nop_count), 34'(2 * Q_PER_INSTR));
    rd(ADDR_IRQ_CTRL, 8'h12, RESP_OKAY);
    check(34'(stack_depth), 34'd1);
    op(2'd0);
    tick(16);
    check(34'(vec_count), 34'd2);
    wr(ADDR_IRQ_CTRL, 8'h10, RESP_OKAY);
    op(2'd0);
    tick(16);
    check(34'(vec_count), 34'd2);
    rd(ADDR_IRQ_CTRL, 8'h90, RESP_OKAY);
    check(34'(stack_depth), 34'd0);
    op(2'd1);
    tick(1);
    check(34'(exec_nop), 34'h1);
    rd(ADDR_IRQ_CTRL, 8'h10, RESP_OKAY);
    // Enabled source held off by cleared global enable
    wr(ADDR_IRQ_CTRL, 8'h20, RESP_OKAY);
    ovf();
    check(34'(irq_request), 34'h0);
    rd(ADDR_IRQ_CTRL, 8'h24, RESP_OKAY);
    // Wake without vector, then wake with vector
    wr(ADDR_IRQ_CTRL, 8'h20, RESP_OKAY);
    op(2'd2);
    tick(2);
    check(34'(core_asleep), 34'h1);
    // Pin edge with its enable clear must not wake
    ext_irq_pin <= 1'b1;
    tick(2);
    ext_irq_pin <= 1'b0;
    tick(3);
    check(34'(core_asleep), 34'h1);
    ovf();
    tick(12);
    check(34'(core_asleep), 34'h0);
    check(34'(wake_count), 34'd1);
    check(34'(vec_count), 34'd2);
    wr(ADDR_IRQ_CTRL, 8'h20, RESP_OKAY);
    op(2'd2);
    tick(2);
    wr(ADDR_IRQ_CTRL, 8'ha0, RESP_OKAY);
    ovf();
    tick(24);
    check(34'(wake_count), 34'd2);
    check(34'(vec_count), 34'd3);
    // Peripheral source through its own enable
    wr(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
    wr(ADDR_PERIPH_EN, 8'h01, RESP_OKAY);
    periph_event <= 1'b1;
    tick(1);
    periph_event <= 1'b0;
    tick(3);
    check(34'(irq_request), 34'h0);
    wr(ADDR_IRQ_CTRL, 8'h80, RESP_OKAY);
    tick(16);
    check(34'(vec_count), 34'd4);
    tally_and_finish();
  end
endmodule
